// [design/tsi_pkg.sv]
// shared constants and carriers for the output slot connection logic
// assumes one 20 MHz system clock; serial timing arrives on pins
package tsi_pkg;
	// ===========================================================
	// switch geometry
	localparam int STREAMS     = 4;    // serial output streams
	localparam int STREAM_W    = 2;    // stream number width
	localparam int CHAN_W      = 5;    // 32 channels per stream
	localparam int ENTRY_W     = STREAM_W + CHAN_W;
	localparam int BYTE_W      = 8;
	localparam int FRAME_W     = 9;    // serial clock cycles per frame, log2
	localparam int SLOT_LOW    = 4;    // low count bits inside one channel
	// ===========================================================
	// control entry fields
	localparam int CS_BIT      = 2;    // channel-source flag
	localparam int OE_BIT      = 0;    // output-enable flag
	// source entry fields
	localparam int STR_MSB     = 6;    // source stream number, msb
	localparam int STR_LSB     = 5;
	localparam int CHN_MSB     = 4;    // source channel number, msb
	localparam int CHN_LSB     = 0;
	// ===========================================================
	// clock rate
	localparam int SYS_CLK_HZ  = 20_000_000;
	localparam logic [FRAME_W-1:0] COUNT_ZERO = 9'h000;
	localparam logic [FRAME_W-1:0] COUNT_ONE  = 9'h001;
	localparam logic [SLOT_LOW-1:0] SLOT_START = 4'h0;
	localparam logic [BYTE_W-1:0] BYTE_ZERO   = 8'h00;
	// ===========================================================
	// entry access request from the processor side
	typedef struct packed {
		logic               write;   // one-cycle write strobe
		logic               read;    // one-cycle read strobe
		logic               high;    // 1 selects the control entry
		logic [ENTRY_W-1:0] addr;    // {stream, channel}
		logic [BYTE_W-1:0]  data;    // write data
	} tsi_entry_req_type;
	// received byte from the serial input path
	typedef struct packed {
		logic               write;
		logic [ENTRY_W-1:0] addr;    // {stream, channel}
		logic [BYTE_W-1:0]  data;
	} tsi_rx_byte_type;
endpackage

// [design/tsi_output_select.sv]
// connection entries and serial output selection for all output streams
// assumes entry requests and received bytes come from sys_clk logic;
// serial clock, frame pulse and output-drive pin are asynchronous pins
// How it works
// - unstored control entry bits read zero
// - channel-source set sends stored source byte
// - channel-source clear switches addressed received byte
// - output-enable flag gates driver when allowed
// - source bits 6-5 give stream number
// - source bits 4-0 give channel number
// - flag or processor mode sends byte unchanged
// - drive pin low forces all outputs off
// - processor mode treats both flags as set
`timescale 1ns/1ns
module tsi_output_select
	import tsi_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic                     serialClkN,     // 4.096 MHz serial clock pin
	input  wire logic                     framePulseN,    // 8 kHz frame pulse pin, active low
	input  wire logic                     globalOutputDrivePin,
	input  wire logic                     processorModeBit,
	input  wire tsi_entry_req_type        entryReq,
	input  wire tsi_rx_byte_type          rxByte,
	output logic [BYTE_W-1:0]             entryRdData,
	output logic                          entryRdValid,
	output logic [STREAMS-1:0]            serialOutputStreams,
	output logic [STREAMS-1:0]            serialOutputEnable
);
	// ===========================================================
	// storage
	logic [1:0]        controlMem [2**ENTRY_W];   // {cs, oe} per slot
	logic [BYTE_W-1:0] sourceMem  [2**ENTRY_W];   // source entry per slot
	logic [BYTE_W-1:0] dataMem    [2**ENTRY_W];   // received bytes

	// pin synchronisers; first stage read only by second
	logic [1:0] clkSync;
	logic       clkPrev;                            // edge history
	logic [1:0] frameSync;
	logic [1:0] driveSync;
	logic       driveOn;                            // synced drive pin

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clkSync   <= 2'h3;
			clkPrev   <= 1'h1;
			frameSync <= 2'h3;
			driveSync <= 2'h0;
		end else begin
			clkSync   <= {clkSync[0], serialClkN};
			clkPrev   <= clkSync[1];
			frameSync <= {frameSync[0], framePulseN};
			driveSync <= {driveSync[0], globalOutputDrivePin};
		end
	end
	// drive pin resets low, so no driver turns on before the pin is seen high
	assign driveOn = driveSync[1];

	// ===========================================================
	// frame timing
	logic               tick;                       // falling serial clock edge
	logic [FRAME_W-1:0] count;                      // serial clocks into frame
	logic [FRAME_W-1:0] next_count;
	logic               loadTick;                   // start of a channel slot
	logic               shiftTick;                  // start of a new bit
	logic [CHAN_W-1:0]  nextChan;

	assign tick       = clkPrev & ~clkSync[1];
	// frame pulse seen low at the edge restarts the count
	// a missing frame pulse lets the count wrap on its own after a full frame
	assign next_count = (~frameSync[1]) ? COUNT_ZERO : FRAME_W'(count + COUNT_ONE);
	assign nextChan   = next_count[FRAME_W-1:SLOT_LOW];
	assign loadTick   = tick & (next_count[SLOT_LOW-1:0] == SLOT_START);
	// one data bit spans two serial clocks
	assign shiftTick  = tick & ~next_count[0] & ~loadTick;

	// counter free-runs between frame pulses
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= COUNT_ZERO;
		end else if (tick) begin
			count <= next_count;
		end
	end

	// ===========================================================
	// processor side and received byte writes; memories carry no reset, contents start unknown
	always_ff @(posedge sys_clk) begin
		if (entryReq.write && entryReq.high) begin
			controlMem[entryReq.addr] <= {entryReq.data[CS_BIT], entryReq.data[OE_BIT]};
		end
		if (entryReq.write && !entryReq.high) begin
			sourceMem[entryReq.addr] <= entryReq.data;
		end
		if (rxByte.write) begin
			dataMem[rxByte.addr] <= rxByte.data;
		end
	end

	// entry read answers one cycle after the strobe
	logic readHigh;                                 // previous cycle's request selected a control entry
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			entryRdData  <= BYTE_ZERO;
			entryRdValid <= 1'b0;
			readHigh     <= 1'b0;
		end else begin
			entryRdValid <= entryReq.read;
			readHigh     <= entryReq.high;
			if (entryReq.read && entryReq.high) begin
				entryRdData <= BYTE_ZERO;
				entryRdData[CS_BIT] <= controlMem[entryReq.addr][1];
				entryRdData[OE_BIT] <= controlMem[entryReq.addr][0];
			end else if (entryReq.read) begin
				entryRdData <= sourceMem[entryReq.addr];
			end
		end
	end

	// ===========================================================
	// per-stream selection and shifting
	logic [BYTE_W-1:0] shiftReg [STREAMS];
	logic [STREAMS-1:0] slotEnable;                 // latched driver flag for slot

	genvar s;
	generate
		for (s = 0; s < STREAMS; s++) begin : g_stream
			logic [ENTRY_W-1:0] slotIdx;
			logic [BYTE_W-1:0]  srcEntry;
			logic               constMode;
			logic [ENTRY_W-1:0] rxIdx;
			assign slotIdx  = {STREAM_W'(s), nextChan};
			assign srcEntry = sourceMem[slotIdx];
			assign constMode = controlMem[slotIdx][1] | processorModeBit;
			assign rxIdx = {srcEntry[STR_MSB:STR_LSB], srcEntry[CHN_MSB:CHN_LSB]};

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					shiftReg[s]   <= BYTE_ZERO;
					slotEnable[s] <= 1'b0;
				end else if (loadTick) begin
					shiftReg[s]   <= constMode ? srcEntry : dataMem[rxIdx];
					slotEnable[s] <= controlMem[slotIdx][0] | processorModeBit;
				end else if (shiftTick) begin
					shiftReg[s]   <= {shiftReg[s][BYTE_W-2:0], 1'b0};
				end
			end

			// outputs registered; msb leaves first
			// enable lags the drive pin by the two sync flops plus this register
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					serialOutputStreams[s] <= 1'b0;
					serialOutputEnable[s]  <= 1'b0;
				end else begin
					serialOutputStreams[s] <= shiftReg[s][BYTE_W-1];
					serialOutputEnable[s]  <= driveOn & slotEnable[s];
				end
			end
		end
	endgenerate

	// ===========================================================
	// checks
	// memories start unknown, so every check on stored content except a_pe_byte, and a_first_bit in processor mode, waits for a
	// programmed control entry in its antecedent; an unknown entry never matches
	// only stream 0 is watched, except a_drive_low_off on all four enables; the other streams share the same generate body
	logic [ENTRY_W-1:0] chkIdx;
	assign chkIdx = g_stream[0].slotIdx;

	a_read_zero_bits: assert property (@(posedge sys_clk) disable iff (rst)
		entryRdValid && readHigh |-> entryRdData[7:3] == 5'h00 && entryRdData[1] == 1'b0)
		else $error("unstored control bits not zero");
	a_const_byte: assert property (@(posedge sys_clk) disable iff (rst)
		loadTick && controlMem[chkIdx][1] |=> shiftReg[0] == $past(sourceMem[chkIdx]))
		else $error("constant byte not loaded");
	a_switched_byte: assert property (@(posedge sys_clk) disable iff (rst)
		loadTick && !controlMem[chkIdx][1] && !processorModeBit
		|=> shiftReg[0] == $past(dataMem[g_stream[0].rxIdx]))
		else $error("switched byte wrong");
	a_oe_flag_off: assert property (@(posedge sys_clk) disable iff (rst)
		loadTick && !processorModeBit && !controlMem[chkIdx][0] |=> ##1 !serialOutputEnable[0])
		else $error("disabled slot driven");
	a_stream_field: assert property (@(posedge sys_clk) disable iff (rst)
		loadTick && !controlMem[chkIdx][1] && !processorModeBit
		|-> g_stream[0].rxIdx[ENTRY_W-1] == sourceMem[chkIdx][STR_MSB]
		&& g_stream[0].rxIdx[CHAN_W] == sourceMem[chkIdx][STR_LSB])
		else $error("stream field misread");
	a_chan_field: assert property (@(posedge sys_clk) disable iff (rst)
		loadTick && !controlMem[chkIdx][1] && !processorModeBit
		|-> g_stream[0].rxIdx[CHAN_W-1] == sourceMem[chkIdx][CHN_MSB]
		&& g_stream[0].rxIdx[CHAN_W-1:0] == sourceMem[chkIdx][CHN_MSB:CHN_LSB])
		else $error("channel field misread");
	a_pe_byte: assert property (@(posedge sys_clk) disable iff (rst)
		loadTick && processorModeBit |=> shiftReg[0] == $past(sourceMem[chkIdx]))
		else $error("processor mode byte wrong");
	a_drive_low_off: assert property (@(posedge sys_clk) disable iff (rst)
		!driveOn |=> serialOutputEnable == 4'h0)
		else $error("output driven with drive pin low");
	a_pe_enable: assert property (@(posedge sys_clk) disable iff (rst)
		loadTick && processorModeBit ##1 driveOn |=> serialOutputEnable[0])
		else $error("processor mode not driving");
	a_first_bit: assert property (@(posedge sys_clk) disable iff (rst)
		loadTick ##1 (driveOn && slotEnable[0]) |=> serialOutputStreams[0] == $past(shiftReg[0][BYTE_W-1]))
		else $error("first bit not presented");

	c_const_slot:  cover property (@(posedge sys_clk) loadTick && controlMem[chkIdx][1]);
	c_switch_slot: cover property (@(posedge sys_clk) loadTick && !controlMem[chkIdx][1] && !processorModeBit);
	c_pe_driven:   cover property (@(posedge sys_clk) processorModeBit && serialOutputEnable[0]);
	c_high_read:   cover property (@(posedge sys_clk) entryRdValid && readHigh);
	c_drive_off:   cover property (@(posedge sys_clk) !driveOn && processorModeBit && loadTick);
endmodule

// [testbench/tsi_serial_far_end.sv]
// far end of the serial output streams: serial clock, frame pulse, slot capture
// assumes the device shifts each slot msb first, one bit every two serial clocks
`timescale 1ns/1ns
module tsi_serial_far_end
	import tsi_pkg::*;
(
	output logic                    serialClkN,
	output logic                    framePulseN,
	input  wire logic [STREAMS-1:0] serialOutputStreams,
	input  wire logic [STREAMS-1:0] serialOutputEnable
);
	logic [FRAME_W-1:0] cnt = COUNT_ZERO;   // serial clocks into the frame
	logic [BYTE_W-1:0]  capD [STREAMS][32]; // captured slot bytes
	logic               capE [STREAMS][32]; // driver state seen at each slot msb
	logic               fpReg = 1'b1;       // frame pulse, idle high
	assign framePulseN = fpReg;
	// ==========================================================
	// serial clock, a little slow so the device sync chain keeps margin
	initial begin
		serialClkN = 1'b1;
		forever #150 serialClkN = ~serialClkN;
	end
	// frame count advances on every falling edge
	always @(negedge serialClkN) cnt <= cnt + COUNT_ONE;
	// frame pulse straddles the falling edge that starts count zero
	always @(posedge serialClkN) fpReg <= (cnt != 9'h1ff);
	always @(posedge serialClkN) begin
		if (cnt[0]) begin
			for (int s = 0; s < STREAMS; s++) begin
				capD[s][cnt[8:4]][7 - cnt[3:1]] <= serialOutputStreams[s];
				// driver state is taken once, at the msb of the slot
				if (cnt[3:1] == 3'h0) capE[s][cnt[8:4]] <= serialOutputEnable[s];
			end
		end
	end
endmodule

// [testbench/tb.sv]
// self-checking bench for the output slot selection
// assumes the far-end model makes serial timing and captures every slot
`timescale 1ns/1ns
module tb import tsi_pkg::*; ;
	logic               sys_clk = 1'b0;
	logic               rst     = 1'b1;
	logic               drive   = 1'b0; // global output-drive pin
	logic               mode    = 1'b0; // processor mode
	tsi_entry_req_type  req     = '0;
	tsi_rx_byte_type    rx      = '0;
	logic [BYTE_W-1:0]  rdData;
	logic               rdValid;
	logic               sclkN;
	logic               fpN;
	logic [STREAMS-1:0] txD;
	logic [STREAMS-1:0] txE;
	logic [BYTE_W-1:0]  ctlMem [128]; // bench copies of what was written
	logic [BYTE_W-1:0]  srcMem [128];
	logic [BYTE_W-1:0]  rxMem  [128];
	int                 fails = 0;
	int                 numChecks = 0;
	// ==========================================================
	tsi_output_select dut_u (
		.sys_clk(sys_clk), .rst(rst), .serialClkN(sclkN), .framePulseN(fpN),
		.globalOutputDrivePin(drive), .processorModeBit(mode), .entryReq(req), .rxByte(rx),
		.entryRdData(rdData), .entryRdValid(rdValid), .serialOutputStreams(txD), .serialOutputEnable(txE)
	);
	tsi_serial_far_end far_u (
		.serialClkN(sclkN), .framePulseN(fpN), .serialOutputStreams(txD), .serialOutputEnable(txE)
	);
	initial forever #25 sys_clk = ~sys_clk;
	// ==========================================================
	task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check1(string what, logic exp, logic got);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one entry access; strobes stay up so back-to-back calls never glitch
	task automatic access(logic wr, logic rd, logic hi, int a, logic [7:0] d);
		req <= '{write: wr, read: rd, high: hi, addr: a[6:0], data: d};
		@(posedge sys_clk);
		#5;
	endtask
	// bounded wait for whole frames, counted on frame pulse falls
	task automatic wait_frames(int n);
		int k;
		int lim;
		logic prev;
		lim = 3200 * n;
		prev = fpN;
		for (k = 0; k < lim && n > 0; k++) begin
			@(posedge sys_clk);
			if (prev === 1'b1 && fpN === 1'b0) n--;
			prev = fpN;
		end
		#5;
		if (n > 0) begin
			fails++;
			$display("mismatch frame wait expected pulse seen none");
			tally_and_finish();
		end
	endtask
	// what a slot should carry: the byte itself or the addressed received byte
	function automatic logic [7:0] exp_data(int i);
		logic [7:0] s;
		s = srcMem[i];
		return (ctlMem[i][CS_BIT] | mode) ? s : rxMem[{s[STR_MSB:STR_LSB], s[CHN_MSB:CHN_LSB]}];
	endfunction
	task automatic check_slots(string name);
		logic en;
		for (int i = 0; i < 128; i++) begin
			en = drive & (ctlMem[i][OE_BIT] | mode);
			check1("slot enable", en, far_u.capE[i/32][i%32]);
			if (en) check8("slot byte", exp_data(i), far_u.capD[i/32][i%32]);
		end
		$display("test %s done", name);
	endtask
	// ==========================================================
	initial begin
		void'($urandom(32'h1a98));
		repeat (8) @(posedge sys_clk);
		#5 rst = 1'b0;
		// drive stays low while programming
		// bytes and source entries first: no switched slot then reads an unwritten byte
		for (int i = 0; i < 128; i++) begin
			// entry 0 is the corner: stray top bit, stream 2 channel 19, junk control bits
			srcMem[i] = (i == 0) ? 8'hd3 : 8'($urandom);
			rxMem[i] = 8'($urandom);
			rx <= '{write: 1'b1, addr: i[6:0], data: rxMem[i]};
			access(1'b1, 1'b0, 1'b0, i, srcMem[i]);
		end
		rx <= '0;
		for (int i = 0; i < 128; i++) begin
			ctlMem[i] = (i == 0) ? 8'hf9 : 8'($urandom);
			access(1'b1, 1'b0, 1'b1, i, ctlMem[i]);
		end
		for (int i = 0; i < 128; i++) begin
			access(1'b0, 1'b1, 1'b1, i, 8'h00);
			check1("read valid", 1'b1, rdValid);
			check8("control read", {5'h00, ctlMem[i][CS_BIT], 1'b0, ctlMem[i][OE_BIT]}, rdData);
			access(1'b0, 1'b1, 1'b0, i, 8'h00);
			check8("source read", srcMem[i], rdData);
		end
		req <= '0;
		$display("test readback done");
		drive <= 1'b1;
		wait_frames(3);
		check_slots("switching");
		mode <= 1'b1;
		wait_frames(3);
		check_slots("processor mode");
		drive <= 1'b0;
		wait_frames(3);
		check_slots("drive off");
		tally_and_finish();
	end
endmodule
